// file: hdl/sfs_map.svh
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

// command bytes
`define SFS_CMD_RD_STAT1   8'h05
`define SFS_CMD_RD_STAT2   8'h35
`define SFS_CMD_WR_STAT    8'h01
`define SFS_CMD_WR_EN      8'h06
`define SFS_CMD_WR_DIS     8'h04
`define SFS_CMD_PROGRAM    8'h02
`define SFS_CMD_ERASE      8'h20
`define SFS_CMD_SEC_ERASE  8'h44
`define SFS_CMD_SUSPEND    8'h75
`define SFS_CMD_RESUME     8'h7A

// first status byte fields
`define SFS_S1_READY_BUSY  0
`define SFS_S1_WEL         1
`define SFS_S1_BP_LO       2
`define SFS_S1_BP_HI       5
`define SFS_S1_QUAD_SINGLE 6
`define SFS_S1_LOCKOUT     7
`define SFS_S1_WR_MASK     8'hFC

// second status byte fields
`define SFS_S2_GUARD_HIGH  0
`define SFS_S2_QUAD        1
`define SFS_S2_PROG_PAUSE  2
`define SFS_S2_LOCK_LO     3
`define SFS_S2_LOCK_HI     5
`define SFS_S2_INVERT      6
`define SFS_S2_ERASE_PAUSE 7
`define SFS_S2_WR_MASK     8'h43
`define SFS_S2_LOCK_MASK   8'h38

// reset values
`define SFS_S1_RESET       8'h00
`define SFS_S2_RESET       8'h02

// internal operation time
`define SFS_CLK_NS         10
`define SFS_BUSY_NS        2000
`define SFS_BUSY_CYC       ((`SFS_BUSY_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)

`endif

// file: hdl/sfs_pkg.sv
package sfs_pkg;

    typedef struct packed {
        logic       sck;
        logic       cs_n;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic [7:0] cmd;
        logic [7:0] arg;
        logic [7:0] stat1;
        logic [7:0] stat2;
        logic [15:0] busy_cnt;
        logic       op_erase;
        logic       miso;
        logic       miso_oe;
        logic       quad;
        logic       locked;
    } sfs_state_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
        logic wp_n;
    } sfs_pins_t;

endpackage

// file: hdl/sfs_status_regs.sv
`include "sfs_map.svh"
`timescale 1ns/1ns
`default_nettype none

module sfs_status_regs
    import sfs_pkg::*;
#(
    parameter bit          DUAL_STATUS = 1'b1,
    parameter logic [15:0] BUSY_CYC    = 16'(`SFS_BUSY_CYC)
) (
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic mosi_i,
    input  wire logic wp_n_i,
    output logic      miso_o,
    output logic      miso_oe_o,
    output logic      quad_io_o,
    output logic      array_locked_o
);

    sfs_state_t s_q;
    sfs_state_t s_d;
    sfs_pins_t  pin;

    assign pin = '{sck: sck_i, cs_n: cs_n_i, mosi: mosi_i, wp_n: wp_n_i};

    // byte returned for a status read
    function automatic logic [7:0] stat_view(input sfs_state_t s, input logic [7:0] c);
        stat_view = (c == `SFS_CMD_RD_STAT2 && DUAL_STATUS) ? s.stat2 : s.stat1;
    endfunction

    // protection of the main array
    function automatic logic prot_active(input logic [7:0] s1, input logic [7:0] s2);
        if (DUAL_STATUS) begin
            prot_active = (|s1[4:`SFS_S1_BP_LO]) ^ s2[`SFS_S2_INVERT];
        end else begin
            prot_active = |s1[`SFS_S1_BP_HI:`SFS_S1_BP_LO];
        end
    endfunction

    logic       rise;
    logic       fall;
    logic       frame_end;
    logic [7:0] byte_in;
    logic       is_read;
    logic       wr_allowed;

    assign rise       = !pin.cs_n && pin.sck && !s_q.sck;
    assign fall       = !pin.cs_n && !pin.sck && s_q.sck;
    assign frame_end  = pin.cs_n && !s_q.cs_n;
    assign byte_in    = {s_q.shift_in[6:0], pin.mosi};
    assign is_read    = s_q.cmd == `SFS_CMD_RD_STAT1 ||
                        (DUAL_STATUS && s_q.cmd == `SFS_CMD_RD_STAT2);
    // lockout guard holds while the protect pin is low and not a data line, or at any pin level once guard-high is set
    assign wr_allowed = s_q.stat1[`SFS_S1_WEL] &&
                        !(s_q.stat1[`SFS_S1_LOCKOUT] && !pin.wp_n && !s_q.quad) &&
                        !(DUAL_STATUS && s_q.stat2[`SFS_S2_GUARD_HIGH] &&
                          s_q.stat1[`SFS_S1_LOCKOUT]);

    always_comb begin
        s_d      = s_q;
        s_d.sck  = pin.sck;
        s_d.cs_n = pin.cs_n;

        // internal operation countdown
        if (s_q.stat1[`SFS_S1_READY_BUSY]) begin
            if (s_q.busy_cnt <= 16'h0001) begin
                s_d.busy_cnt                 = 16'h0000;
                s_d.stat1[`SFS_S1_READY_BUSY] = 1'b0;
                s_d.stat1[`SFS_S1_WEL]        = 1'b0;
            end else begin
                s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
            end
        end

        if (pin.cs_n) begin
            s_d.bit_cnt  = 3'h0;
            s_d.byte_cnt = 2'h0;
            s_d.miso_oe  = 1'b0;
        end

        // mode 3: capture on rising, launch on falling
        if (rise) begin
            s_d.shift_in = byte_in;
            s_d.bit_cnt  = s_q.bit_cnt + 3'h1;
            if (s_q.bit_cnt == 3'h7) begin
                if (s_q.byte_cnt != 2'h3) begin
                    s_d.byte_cnt = s_q.byte_cnt + 2'h1;
                end
                case (s_q.byte_cnt)
                    2'h0: begin
                        s_d.cmd       = byte_in;
                        s_d.shift_out = stat_view(s_q, byte_in);
                    end
                    2'h1: begin
                        s_d.arg = byte_in;
                    end
                    2'h2: begin
                        if (s_q.cmd == `SFS_CMD_WR_STAT && DUAL_STATUS) begin
                            s_d.shift_in = byte_in;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (fall) begin
            if (s_q.byte_cnt == 2'h1 && is_read) begin
                s_d.miso_oe   = 1'b1;
                s_d.miso      = s_q.shift_out[7];
                s_d.shift_out = {s_q.shift_out[6:0], 1'b0};
            end else begin
                s_d.miso_oe = 1'b0;
            end
        end

        // commands act when the frame closes on a byte boundary
        if (frame_end && s_q.bit_cnt == 3'h0 && s_q.byte_cnt != 2'h0) begin
            case (s_q.cmd)
                `SFS_CMD_WR_EN: begin
                    if (!s_q.stat1[`SFS_S1_READY_BUSY]) begin
                        s_d.stat1[`SFS_S1_WEL] = 1'b1;
                    end
                end
                `SFS_CMD_WR_DIS: begin
                    if (!s_q.stat1[`SFS_S1_READY_BUSY]) begin
                        s_d.stat1[`SFS_S1_WEL] = 1'b0;
                    end
                end
                `SFS_CMD_WR_STAT: begin
                    if (!s_q.stat1[`SFS_S1_READY_BUSY] && wr_allowed &&
                        s_q.byte_cnt >= 2'h2) begin
                        s_d.stat1 = (s_q.stat1 & ~`SFS_S1_WR_MASK) |
                                    (s_q.arg & `SFS_S1_WR_MASK);
                        if (DUAL_STATUS && s_q.byte_cnt == 2'h3) begin
                            s_d.stat2 = (s_q.stat2 & ~`SFS_S2_WR_MASK) |
                                        (s_q.shift_in & `SFS_S2_WR_MASK) |
                                        (s_q.shift_in & `SFS_S2_LOCK_MASK);
                        end
                        s_d.stat1[`SFS_S1_WEL]        = 1'b1;
                        s_d.stat1[`SFS_S1_READY_BUSY] = 1'b1;
                        s_d.busy_cnt                  = BUSY_CYC;
                    end
                end
                `SFS_CMD_PROGRAM,
                `SFS_CMD_ERASE: begin
                    if (!s_q.stat1[`SFS_S1_READY_BUSY] && s_q.stat1[`SFS_S1_WEL] &&
                        !s_q.locked && !s_q.stat2[`SFS_S2_ERASE_PAUSE] &&
                        !s_q.stat2[`SFS_S2_PROG_PAUSE]) begin
                        s_d.stat1[`SFS_S1_READY_BUSY] = 1'b1;
                        s_d.busy_cnt                  = BUSY_CYC;
                        s_d.op_erase                  = s_q.cmd == `SFS_CMD_ERASE;
                    end else begin
                        s_d.stat1[`SFS_S1_WEL] = s_q.stat1[`SFS_S1_READY_BUSY] &
                                                 s_q.stat1[`SFS_S1_WEL];
                    end
                end
                `SFS_CMD_SEC_ERASE: begin
                    // page number travels in the argument byte, 1 to 3
                    if (DUAL_STATUS && !s_q.stat1[`SFS_S1_READY_BUSY] &&
                        s_q.stat1[`SFS_S1_WEL] && s_q.arg >= 8'h01 && s_q.arg <= 8'h03 &&
                        !s_q.stat2[`SFS_S2_LOCK_LO + 32'(s_q.arg[1:0]) - 1]) begin
                        s_d.stat1[`SFS_S1_READY_BUSY] = 1'b1;
                        s_d.busy_cnt                  = BUSY_CYC;
                        s_d.op_erase                  = 1'b1;
                    end
                end
                `SFS_CMD_SUSPEND: begin
                    if (DUAL_STATUS && s_q.stat1[`SFS_S1_READY_BUSY] &&
                        s_q.busy_cnt > 16'h0001) begin
                        s_d.stat1[`SFS_S1_READY_BUSY] = 1'b0;
                        s_d.busy_cnt                  = s_q.busy_cnt;
                        if (s_q.op_erase) begin
                            s_d.stat2[`SFS_S2_ERASE_PAUSE] = 1'b1;
                        end else begin
                            s_d.stat2[`SFS_S2_PROG_PAUSE] = 1'b1;
                        end
                    end
                end
                `SFS_CMD_RESUME: begin
                    if (s_q.stat2[`SFS_S2_ERASE_PAUSE] || s_q.stat2[`SFS_S2_PROG_PAUSE]) begin
                        s_d.stat2[`SFS_S2_ERASE_PAUSE] = 1'b0;
                        s_d.stat2[`SFS_S2_PROG_PAUSE]  = 1'b0;
                        s_d.stat1[`SFS_S1_READY_BUSY]  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        s_d.quad   = DUAL_STATUS ? s_d.stat2[`SFS_S2_QUAD]
                                 : s_d.stat1[`SFS_S1_QUAD_SINGLE];
        s_d.locked = prot_active(s_d.stat1, s_d.stat2);
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q       <= '0;
            s_q.sck   <= 1'b1;
            s_q.cs_n  <= 1'b1;
            s_q.stat1 <= `SFS_S1_RESET;
            s_q.stat2 <= DUAL_STATUS ? `SFS_S2_RESET : 8'h00;
            s_q.quad  <= DUAL_STATUS;
        end else begin
            s_q <= s_d;
        end
    end

    assign miso_o         = s_q.miso;
    assign miso_oe_o      = s_q.miso_oe;
    assign quad_io_o      = s_q.quad;
    assign array_locked_o = s_q.locked;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    ready_on_done_a: assert property (
        s_q.stat1[0] && s_q.busy_cnt == 16'h0001 && !frame_end |=> !s_q.stat1[0] && !s_q.stat1[1])
        else $error("busy flag did not clear at end of operation");

    wel_clear_a: assert property (
        frame_end && s_q.bit_cnt == 3'h0 && s_q.byte_cnt != 2'h0 &&
        s_q.cmd == `SFS_CMD_WR_DIS && !s_q.stat1[0] |=> !s_q.stat1[1])
        else $error("write disable left latch set");

    lock_sticky_a: assert property (
        s_q.stat2[5:3] != 3'h0 |=> (s_q.stat2[5:3] & $past(s_q.stat2[5:3])) == $past(s_q.stat2[5:3]))
        else $error("security lock bit dropped");

    sec_ignore_a: assert property (
        frame_end && s_q.bit_cnt == 3'h0 && s_q.cmd == `SFS_CMD_SEC_ERASE && !s_q.stat1[0] &&
        s_q.arg == 8'h02 && s_q.stat2[4] |=> !s_q.stat1[0])
        else $error("erase of locked security page started");

    erase_pause_a: assert property (
        DUAL_STATUS && frame_end && s_q.bit_cnt == 3'h0 && s_q.byte_cnt != 2'h0 &&
        s_q.cmd == `SFS_CMD_SUSPEND &&
        s_q.stat1[0] && s_q.op_erase && s_q.busy_cnt > 16'h0001 |=> s_q.stat2[7] && !s_q.stat1[0])
        else $error("erase suspend not flagged");

    one_byte_a: assert property (
        s_q.miso_oe |-> s_q.byte_cnt inside {2'h1, 2'h2} && is_read)
        else $error("status drive outside single byte");

    mode3_launch_a: assert property (
        fall && s_q.byte_cnt == 2'h1 && is_read |=> s_q.miso == $past(s_q.shift_out[7]) && s_q.miso_oe)
        else $error("status bit not launched on falling edge");

    quad_map_a: assert property (
        s_q.quad == (DUAL_STATUS ? s_q.stat2[1] : s_q.stat1[6]))
        else $error("quad select output disagrees with status");

    array_lock_a: assert property (
        !DUAL_STATUS |-> s_q.locked == (|s_q.stat1[5:2]))
        else $error("array protection disagrees with level bits");

    invert_lock_a: assert property (
        DUAL_STATUS |-> s_q.locked == ((|s_q.stat1[4:2]) ^ s_q.stat2[6]))
        else $error("inverted protection disagrees with status");

endmodule // sfs_status_regs

`default_nettype wire

// file: test/sfs_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module sfs_host_model (
    input  wire logic core_clk_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    logic [7:0] rx_q;
    int         oe_cnt;

    initial begin
        sck_o  = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // each sck level lasts 4 core cycles, above the 1 the slave needs
    task automatic half();
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask

    task automatic frame(input logic [23:0] tx, input int nbits);
        rx_q   = 8'h00;
        oe_cnt = 0;
        @(posedge core_clk_i);
        #1;
        cs_n_o = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            sck_o  = 1'b0;
            mosi_o = tx[23 - i];
            half();
            sck_o = 1'b1;
            if (miso_oe_i === 1'b1) begin
                rx_q = {rx_q[6:0], miso_i};
                oe_cnt++;
            end
            half();
        end
        cs_n_o = 1'b1;
        // released line must not keep its last value
        mosi_o = ~mosi_o;
        half();
    endtask
endmodule // sfs_host_model

`default_nettype wire

// file: test/testbench.sv
`include "sfs_map.svh"
`timescale 1ns/1ns
`default_nettype none

module testbench;
    localparam logic [15:0] BUSY = 16'h0096;
    logic       clk;
    logic       rst_n;
    logic       sck;
    logic       cs_n;
    logic       mosi;
    logic       wp_n;
    logic       miso;
    logic       miso_oe;
    logic       quad_io;
    logic       locked;
    logic       locked_s;
    logic [7:0] v;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] exp1;
    logic [7:0] exp2;
    int         num_errors;
    int         n_tests;

    sfs_status_regs #(.DUAL_STATUS(1'b1), .BUSY_CYC(BUSY)) uut (
        .core_clk_i(clk), .reset_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
        .wp_n_i(wp_n), .miso_o(miso), .miso_oe_o(miso_oe), .quad_io_o(quad_io), .array_locked_o(locked));

    // single-status flavour watches the same link, its miso stays unused
    sfs_status_regs #(.DUAL_STATUS(1'b0), .BUSY_CYC(BUSY)) uut_single (
        .core_clk_i(clk), .reset_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
        .wp_n_i(wp_n), .miso_o(), .miso_oe_o(), .quad_io_o(), .array_locked_o(locked_s));

    sfs_host_model host (
        .core_clk_i(clk), .miso_i(miso), .miso_oe_i(miso_oe), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
        n_tests++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e & m, g & m);
        end
    endtask

    task automatic rd(input logic [7:0] c);
        host.frame({c, 16'h0000}, 24);
        v = host.rx_q;
        chk8(8'h08, 8'(host.oe_cnt), 8'hff);
    endtask

    task automatic wr_en();
        host.frame({`SFS_CMD_WR_EN, 16'h0000}, 8);
    endtask

    task automatic wr_stat(input logic [7:0] a, input logic [7:0] b);
        wr_en();
        host.frame({`SFS_CMD_WR_STAT, a, b}, 24);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        wp_n  = 1'b1;
        num_errors = 0;
        n_tests = 0;
        void'($urandom(32'h1a58));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        exp1 = 8'h00;
        exp2 = 8'h02;
        chk8(8'h01, {7'h00, quad_io}, 8'hff);
        rd(`SFS_CMD_RD_STAT1);
        chk8(exp1, v, 8'hff);
        rd(`SFS_CMD_RD_STAT2);
        chk8(exp2, v, 8'hff);
        wr_en();
        rd(`SFS_CMD_RD_STAT1);
        chk8(8'h02, v, 8'hff);
        host.frame({`SFS_CMD_WR_DIS, 16'h0000}, 8);
        rd(`SFS_CMD_RD_STAT1);
        chk8(8'h00, v, 8'hff);
        for (int i = 0; i < 6; i++) begin
            s1 = 8'($urandom());
            s2 = 8'($urandom()) & 8'hc6;
            if (i == 2) s2 = s2 | 8'h08;
            wr_stat(s1, s2);
            rd(`SFS_CMD_RD_STAT1);
            chk8(8'h03, v, 8'h03);
            repeat (200) @(posedge clk);
            exp1 = s1 & 8'hfc;
            exp2 = (s2 & 8'h43) | ((exp2 | s2) & 8'h38);
            rd(`SFS_CMD_RD_STAT1);
            chk8(exp1, v, 8'hff);
            rd(`SFS_CMD_RD_STAT2);
            chk8(exp2, v, 8'hff);
            chk8({7'h00, exp2[1]}, {7'h00, quad_io}, 8'h01);
            chk8({7'h00, (|exp1[4:2]) ^ exp2[6]}, {7'h00, locked}, 8'h01);
            chk8({7'h00, |exp1[5:2]}, {7'h00, locked_s}, 8'h01);
        end
        // locked pages refuse erase, so no busy appears
        for (int p = 1; p < 4; p++) begin
            wr_en();
            host.frame({`SFS_CMD_SEC_ERASE, 8'(p), 8'h00}, 16);
            rd(`SFS_CMD_RD_STAT1);
            chk8({7'h00, ~exp2[2 + p]}, v, 8'h01);
            repeat (200) @(posedge clk);
        end
        wr_stat(8'h80, 8'h00);
        repeat (200) @(posedge clk);
        exp1 = 8'h80;
        #1 wp_n = 1'b0;
        wr_stat(8'h1c, 8'h00);
        repeat (200) @(posedge clk);
        rd(`SFS_CMD_RD_STAT1);
        chk8(exp1, v, 8'hfc);
        wp_n = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr_en();
            host.frame({(k == 0) ? `SFS_CMD_ERASE : `SFS_CMD_PROGRAM, 16'h0000}, 16);
            host.frame({`SFS_CMD_SUSPEND, 16'h0000}, 8);
            rd(`SFS_CMD_RD_STAT2);
            chk8((k == 0) ? 8'h80 : 8'h04, v, 8'h84);
            host.frame({`SFS_CMD_RESUME, 16'h0000}, 8);
            repeat (200) @(posedge clk);
            rd(`SFS_CMD_RD_STAT2);
            chk8(8'h00, v, 8'h84);
        end
        wrap_up();
    end
endmodule // testbench

`default_nettype wire
